/* hw/ihu_cfg.svh */
`ifndef IHU_CFG_SVH
`define IHU_CFG_SVH

// Clocking
`define IHU_CLK_HZ        32'h05F5_E100
`define IHU_US_DIV        32'h000F_4240
`define IHU_MS_DIV        32'h0000_03E8
`define IHU_DEV_CLK_HZ    32'h0070_8000
`define IHU_TICK_DIV      32'h0000_0030
`define IHU_TICK_HZ       (`IHU_DEV_CLK_HZ / `IHU_TICK_DIV)

// Start-up and link timing
`define IHU_PWRT_US       32'h0001_1940
`define IHU_OSC_START_US  32'h0000_008B
`define IHU_LINK_TMO_MS   32'h0000_0BB8

// Character framing in bit ticks and data bits
`define IHU_TICK_LAST     4'hF
`define IHU_TICK_MID      4'h7
`define IHU_BIT_LAST      3'h7

// Buffers
`define IHU_HOST_DEPTH    5'h1D
`define IHU_HOST_PTR_LAST 5'h1C
`define IHU_CTS_OFF_LEVEL 5'h17
`define IHU_IR_DEPTH      7'h40

// Register byte offsets
`define IHU_OFF_CTRL      12'h000
`define IHU_OFF_STATUS    12'h004
`define IHU_OFF_REMOTE    12'h008
`define IHU_OFF_LEVELS    12'h00C
`define IHU_OFF_IRDATA    12'h010
`define IHU_OFF_HOSTDATA  12'h014

// Field positions
`define IHU_ST_READY      0
`define IHU_ST_CTS        1
`define IHU_ST_DSR        2
`define IHU_ST_RTS        3
`define IHU_ST_TX_BUSY    4
`define IHU_ST_RX_BUSY    5
`define IHU_ST_HOST_OVF   6
`define IHU_ST_LINK_TMO   7
`define IHU_ST_PENDING    8
`define IHU_RM_CD         0
`define IHU_RM_RI         1
`define IHU_RM_DTR        2
`define IHU_LV_IR_LSB     8
`define IHU_DATA_FLAG     8

`endif

/* hw/ihu_pkg.sv */
package ihu_pkg;
   typedef enum logic [1:0] {IHU_BOOT_PWRUP, IHU_BOOT_OSC_START, IHU_BOOT_RUN} ihu_boot_type;
   typedef enum logic [1:0] {IHU_TX_IDLE, IHU_TX_START, IHU_TX_DATA, IHU_TX_STOP} ihu_tx_type;
   typedef enum logic [1:0] {IHU_RX_IDLE, IHU_RX_START, IHU_RX_DATA, IHU_RX_STOP} ihu_rx_type;
   typedef enum logic [1:0] {
      IHU_NORMAL_DISCONNECT_STATE,
      IHU_DISCOVERY_STATE,
      IHU_NORMAL_RESPONSE_STATE,
      IHU_LOW_POWER_STATE
   } ihu_handler_type;
endpackage : ihu_pkg

/* hw/ihu_buffer_mem.sv */
`timescale 1ns/1ps
module ihu_buffer_mem #(
   parameter int DEPTH = 29,
   parameter int AW    = 5
) (
   // Clock
   input  wire logic          clk,
   // Write side
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // Read side
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);
   logic [7:0] store [DEPTH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= wr_data;
      end
   end

   // Registered read: head data lags a pointer move by one cycle
   always_ff @(posedge clk) begin
      rd_data <= store[rd_addr];
   end
endmodule : ihu_buffer_mem

/* hw/ihu_tick_gen.sv */
`timescale 1ns/1ps
`include "ihu_cfg.svh"
module ihu_tick_gen (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset_n,
   // Tick out
   output logic      bit_tick
);
   logic [31:0] acc;
   logic [31:0] next_acc;

   // Fractional accumulator keeps the long-term tick rate exact at 100 MHz
   always_comb begin
      next_acc = acc + `IHU_TICK_HZ;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc      <= 32'h0000_0000;
         bit_tick <= 1'b0;
      end else if (next_acc >= `IHU_CLK_HZ) begin
         acc      <= next_acc - `IHU_CLK_HZ;
         bit_tick <= 1'b1;
      end else begin
         acc      <= next_acc;
         bit_tick <= 1'b0;
      end
   end
endmodule : ihu_tick_gen

/* hw/ihu_host_uart.sv */
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "ihu_cfg.svh"
module ihu_host_uart
   import ihu_pkg::*;
#(
   parameter int unsigned PWRUP_CYCLES        = `IHU_PWRT_US * (`IHU_CLK_HZ / `IHU_US_DIV),
   parameter int unsigned OSC_START_CYCLES    = `IHU_OSC_START_US * (`IHU_CLK_HZ / `IHU_US_DIV),
   parameter int unsigned LINK_TIMEOUT_CYCLES = `IHU_LINK_TMO_MS * (`IHU_CLK_HZ / `IHU_MS_DIV)
) (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Host serial port
   input  wire logic        host_txd,
   output logic             host_rxd,
   // Host modem lines
   input  wire logic        rts_n,
   output logic             cts_n,
   input  wire logic        dtr_n,
   output logic             dsr_n,
   input  wire logic        cd_n,
   input  wire logic        ri_n,
   // Protocol handler status
   output logic             handler_active
);
   localparam int TICK_LO = int'(`IHU_CLK_HZ / `IHU_TICK_HZ);

   ihu_boot_type    boot;
   logic [31:0]     boot_cnt;
   logic            ready;
   logic            bit_tick;
   ihu_handler_type hstate;
   logic            acc;
   logic            done;
   logic [31:0]     rd_value;
   logic            err_value;
   logic            ir_push;
   logic            host_pop;
   logic            st_clear;
   logic [5:0]      ir_wr_ptr;
   logic [5:0]      ir_rd_ptr;
   logic [6:0]      ir_count;
   logic [7:0]      ir_rdata;
   logic            ir_head_ok;
   logic            pkt_pending;
   logic [4:0]      host_wr_ptr;
   logic [4:0]      host_rd_ptr;
   logic [4:0]      host_count;
   logic [7:0]      host_rdata;
   logic            host_head_ok;
   logic            host_push;
   logic            host_drop;
   logic [31:0]     tmo_cnt;
   logic            link_timeout;
   logic            host_ovf;
   logic            link_tmo_flag;
   ihu_tx_type      tx_state;
   logic [3:0]      tx_tick;
   logic [2:0]      tx_bit;
   logic [7:0]      tx_shift;
   logic            tx_go;
   ihu_rx_type      rx_state;
   logic [3:0]      rx_tick;
   logic [2:0]      rx_bit;
   logic [7:0]      rx_shift;

   // Start-up: power-up delay, then oscillator start-up delay
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         boot     <= IHU_BOOT_PWRUP;
         boot_cnt <= 32'h0000_0000;
      end else begin
         case (boot)
            IHU_BOOT_PWRUP: begin
               if (boot_cnt >= PWRUP_CYCLES - 1) begin
                  boot     <= IHU_BOOT_OSC_START;
                  boot_cnt <= 32'h0000_0000;
               end else begin
                  boot_cnt <= boot_cnt + 32'h0000_0001;
               end
            end
            IHU_BOOT_OSC_START: begin
               if (boot_cnt >= OSC_START_CYCLES - 1) begin
                  boot     <= IHU_BOOT_RUN;
                  boot_cnt <= 32'h0000_0000;
               end else begin
                  boot_cnt <= boot_cnt + 32'h0000_0001;
               end
            end
            default: boot <= IHU_BOOT_RUN;
         endcase
      end
   end

   assign ready = (boot == IHU_BOOT_RUN);

   ihu_tick_gen u_tick (
      .clk      (clk),
      .reset_n  (reset_n),
      .bit_tick (bit_tick)
   );

   // APB: one wait state, so every answer comes from a flop
   assign acc  = psel & penable;
   assign done = acc & pready;

   always_comb begin
      rd_value  = 32'h0000_0000;
      err_value = 1'b0;
      case (paddr)
         `IHU_OFF_CTRL: rd_value[1:0] = hstate;
         `IHU_OFF_STATUS: begin
            rd_value[`IHU_ST_READY]    = ready;
            rd_value[`IHU_ST_CTS]      = cts_n;
            rd_value[`IHU_ST_DSR]      = dsr_n;
            rd_value[`IHU_ST_RTS]      = rts_n;
            rd_value[`IHU_ST_TX_BUSY]  = (tx_state != IHU_TX_IDLE);
            rd_value[`IHU_ST_RX_BUSY]  = (rx_state != IHU_RX_IDLE);
            rd_value[`IHU_ST_HOST_OVF] = host_ovf;
            rd_value[`IHU_ST_LINK_TMO] = link_tmo_flag;
            rd_value[`IHU_ST_PENDING]  = pkt_pending;
         end
         `IHU_OFF_REMOTE: begin
            rd_value[`IHU_RM_CD]  = cd_n;
            rd_value[`IHU_RM_RI]  = ri_n;
            rd_value[`IHU_RM_DTR] = dtr_n;
         end
         `IHU_OFF_LEVELS: begin
            rd_value[4:0]                = host_count;
            rd_value[`IHU_LV_IR_LSB +: 7] = ir_count;
         end
         `IHU_OFF_IRDATA: err_value = pwrite & (~ready | (ir_count == `IHU_IR_DEPTH));
         `IHU_OFF_HOSTDATA: begin
            rd_value[7:0]            = host_rdata;
            rd_value[`IHU_DATA_FLAG] = host_head_ok;
         end
         default: err_value = 1'b1;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= acc & ~pready;
         if (acc & ~pready) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_value;
            pslverr <= err_value;
         end
      end
   end

   assign ir_push  = done & pwrite & (paddr == `IHU_OFF_IRDATA) & ~pslverr;
   assign host_pop = done & ~pwrite & (paddr == `IHU_OFF_HOSTDATA) & prdata[`IHU_DATA_FLAG];
   assign st_clear = done & pwrite & (paddr == `IHU_OFF_STATUS);

   // Handler state: software sets it, a link timeout forces disconnect
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hstate <= IHU_NORMAL_DISCONNECT_STATE;
      end else if (link_timeout) begin
         hstate <= IHU_NORMAL_DISCONNECT_STATE;
      end else if (done & pwrite & (paddr == `IHU_OFF_CTRL)) begin
         hstate <= ihu_handler_type'(pwdata[1:0]);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         dsr_n          <= 1'b1;
         handler_active <= 1'b0;
      end else begin
         dsr_n          <= (hstate != IHU_NORMAL_RESPONSE_STATE);
         handler_active <= (hstate == IHU_DISCOVERY_STATE) |
                           (hstate == IHU_NORMAL_RESPONSE_STATE);
      end
   end

   // Infrared-side buffer, filled by software, drained toward the host
   ihu_buffer_mem #(.DEPTH(64), .AW(6)) u_ir_mem (
      .clk     (clk),
      .wr_en   (ir_push),
      .wr_addr (ir_wr_ptr),
      .wr_data (pwdata[7:0]),
      .rd_addr (ir_rd_ptr),
      .rd_data (ir_rdata)
   );

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         ir_wr_ptr  <= 6'h00;
         ir_rd_ptr  <= 6'h00;
         ir_count   <= 7'h00;
         ir_head_ok <= 1'b0;
      end else if (link_timeout) begin
         ir_rd_ptr  <= ir_wr_ptr;
         ir_count   <= 7'h00;
         ir_head_ok <= 1'b0;
      end else begin
         if (ir_push) begin
            ir_wr_ptr <= ir_wr_ptr + 6'h01;
         end
         if (tx_go) begin
            ir_rd_ptr <= ir_rd_ptr + 6'h01;
         end
         ir_count   <= ir_count + {6'h00, ir_push} - {6'h00, tx_go};
         // Registered read needs one cycle after any pointer or count move
         ir_head_ok <= (ir_count != 7'h00) & ~tx_go;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pkt_pending <= 1'b0;
      end else if (link_timeout) begin
         // A byte pushed in the flush cycle is dropped, so it must not mark a packet
         pkt_pending <= 1'b0;
      end else if (ir_push & pwdata[`IHU_DATA_FLAG]) begin
         pkt_pending <= 1'b1;
      end else if (ir_count == 7'h00) begin
         pkt_pending <= 1'b0;
      end
   end

   // Link timeout while the host holds off a received packet
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tmo_cnt <= 32'h0000_0000;
      end else if (pkt_pending & rts_n & ~link_timeout) begin
         tmo_cnt <= tmo_cnt + 32'h0000_0001;
      end else begin
         tmo_cnt <= 32'h0000_0000;
      end
   end

   assign link_timeout = pkt_pending & rts_n & (tmo_cnt >= LINK_TIMEOUT_CYCLES - 1);

   // Host-side buffer, filled by the receiver, emptied by software
   ihu_buffer_mem #(.DEPTH(29), .AW(5)) u_host_mem (
      .clk     (clk),
      .wr_en   (host_push),
      .wr_addr (host_wr_ptr),
      .wr_data (rx_shift),
      .rd_addr (host_rd_ptr),
      .rd_data (host_rdata)
   );

   assign host_push = (rx_state == IHU_RX_STOP) & host_txd & (host_count != `IHU_HOST_DEPTH);
   assign host_drop = (rx_state == IHU_RX_STOP) & host_txd & (host_count == `IHU_HOST_DEPTH);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         host_wr_ptr  <= 5'h00;
         host_rd_ptr  <= 5'h00;
         host_count   <= 5'h00;
         host_head_ok <= 1'b0;
      end else begin
         if (host_push) begin
            host_wr_ptr <= (host_wr_ptr == `IHU_HOST_PTR_LAST) ? 5'h00 : host_wr_ptr + 5'h01;
         end
         if (host_pop) begin
            host_rd_ptr <= (host_rd_ptr == `IHU_HOST_PTR_LAST) ? 5'h00 : host_rd_ptr + 5'h01;
         end
         host_count   <= host_count + {4'h0, host_push} - {4'h0, host_pop};
         host_head_ok <= (host_count != 5'h00) & ~host_pop;
      end
   end

   // Hysteresis stops cts_n chattering around the threshold
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cts_n <= 1'b1;
      end else if (~ready | (host_count >= `IHU_CTS_OFF_LEVEL)) begin
         cts_n <= 1'b1;
      end else if (host_count == 5'h00) begin
         cts_n <= 1'b0;
      end
   end

   // Sticky status; a new event wins over a clear in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         host_ovf      <= 1'b0;
         link_tmo_flag <= 1'b0;
      end else begin
         host_ovf      <= host_drop | (host_ovf & ~(st_clear & pwdata[`IHU_ST_HOST_OVF]));
         link_tmo_flag <= link_timeout | (link_tmo_flag & ~(st_clear & pwdata[`IHU_ST_LINK_TMO]));
      end
   end

   // Transmitter toward the host; starts only while the receiver is idle
   assign tx_go = ready & bit_tick & (tx_state == IHU_TX_IDLE) & (rx_state == IHU_RX_IDLE) &
                  pkt_pending & ir_head_ok & ~rts_n & ~link_timeout;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tx_state <= IHU_TX_IDLE;
         tx_tick  <= 4'h0;
         tx_bit   <= 3'h0;
         tx_shift <= 8'h00;
         host_rxd <= 1'b1;
      end else begin
         case (tx_state)
            IHU_TX_IDLE: begin
               host_rxd <= 1'b1;
               if (tx_go) begin
                  tx_state <= IHU_TX_START;
                  tx_shift <= ir_rdata;
                  tx_tick  <= 4'h0;
                  host_rxd <= 1'b0;
               end
            end
            IHU_TX_START: begin
               if (bit_tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == `IHU_TICK_LAST) begin
                     tx_state <= IHU_TX_DATA;
                     tx_bit   <= 3'h0;
                     host_rxd <= tx_shift[0];
                  end
               end
            end
            IHU_TX_DATA: begin
               if (bit_tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == `IHU_TICK_LAST) begin
                     if (tx_bit == `IHU_BIT_LAST) begin
                        tx_state <= IHU_TX_STOP;
                        host_rxd <= 1'b1;
                     end else begin
                        tx_bit   <= tx_bit + 3'h1;
                        tx_shift <= {1'b0, tx_shift[7:1]};
                        host_rxd <= tx_shift[1];
                     end
                  end
               end
            end
            IHU_TX_STOP: begin
               if (bit_tick) begin
                  tx_tick <= tx_tick + 4'h1;
                  if (tx_tick == `IHU_TICK_LAST) begin
                     tx_state <= IHU_TX_IDLE;
                  end
               end
            end
            default: tx_state <= IHU_TX_IDLE;
         endcase
      end
   end

   // Receiver from the host; the stop bit is not timed, only awaited
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rx_state <= IHU_RX_IDLE;
         rx_tick  <= 4'h0;
         rx_bit   <= 3'h0;
         rx_shift <= 8'h00;
      end else begin
         case (rx_state)
            IHU_RX_IDLE: begin
               if (ready & bit_tick & ~host_txd & (tx_state == IHU_TX_IDLE) & ~tx_go) begin
                  rx_state <= IHU_RX_START;
                  rx_tick  <= 4'h0;
               end
            end
            IHU_RX_START: begin
               if (bit_tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == `IHU_TICK_MID) begin
                     rx_state <= host_txd ? IHU_RX_IDLE : IHU_RX_DATA;
                     rx_tick  <= 4'h0;
                     rx_bit   <= 3'h0;
                  end
               end
            end
            IHU_RX_DATA: begin
               if (bit_tick) begin
                  rx_tick <= rx_tick + 4'h1;
                  if (rx_tick == `IHU_TICK_LAST) begin
                     rx_shift <= {host_txd, rx_shift[7:1]};
                     rx_bit   <= rx_bit + 3'h1;
                     if (rx_bit == `IHU_BIT_LAST) begin
                        rx_state <= IHU_RX_STOP;
                     end
                  end
               end
            end
            IHU_RX_STOP: begin
               if (host_txd) begin
                  rx_state <= IHU_RX_IDLE;
               end
            end
            default: rx_state <= IHU_RX_IDLE;
         endcase
      end
   end

   // Helper for tick spacing
   logic [15:0] tick_gap;
   logic        tick_seen;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         tick_gap  <= 16'h0001;
         tick_seen <= 1'b0;
      end else begin
         tick_gap  <= bit_tick ? 16'h0001 : tick_gap + 16'h0001;
         tick_seen <= tick_seen | bit_tick;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_tick_spacing: assert property (
      bit_tick && tick_seen |-> (tick_gap >= 16'(TICK_LO)) && (tick_gap <= 16'(TICK_LO + 1)))
      else $error("bit tick spacing wrong");

   chk_half_duplex: assert property (
      !((tx_state != IHU_TX_IDLE) && (rx_state != IHU_RX_IDLE)))
      else $error("transmit and receive active together");

   chk_cts_threshold: assert property (
      (host_count >= `IHU_CTS_OFF_LEVEL) |=> cts_n)
      else $error("cts_n not high at threshold");

   chk_cts_release: assert property (
      ready && (host_count == 5'h00) |=> !cts_n)
      else $error("cts_n not low with empty buffer");

   chk_host_capacity: assert property (
      host_count <= `IHU_HOST_DEPTH)
      else $error("host buffer over capacity");

   chk_dsr_link: assert property (
      ##1 (dsr_n == ($past(hstate) != IHU_NORMAL_RESPONSE_STATE)))
      else $error("dsr_n does not follow link state");

   chk_active_out: assert property (
      $changed(hstate) |=> (handler_active == ((hstate == IHU_DISCOVERY_STATE) ||
                                               (hstate == IHU_NORMAL_RESPONSE_STATE))))
      else $error("handler_active wrong");

   chk_tx_needs_rts: assert property (
      (tx_state == IHU_TX_IDLE) ##1 (tx_state == IHU_TX_START) |-> $past(rts_n) == 1'b0)
      else $error("transmit started with rts_n high");

   chk_timeout_drop: assert property (
      link_timeout |=> (hstate == IHU_NORMAL_DISCONNECT_STATE) && !pkt_pending && (ir_count == 7'h00))
      else $error("timeout did not disconnect");

   chk_startup_quiet: assert property (
      !ready |-> cts_n && host_rxd && (rx_state == IHU_RX_IDLE))
      else $error("port active before start-up ends");

   chk_stop_high: assert property (
      (tx_state == IHU_TX_STOP) |-> host_rxd)
      else $error("stop bit not high");
endmodule : ihu_host_uart

/* sim/ihu_host_model.sv */
`timescale 1ns/1ps
module ihu_host_model (
   // Clock
   input  wire logic clk,
   // Serial lines
   output logic      host_txd,
   input  wire logic host_rxd,
   // Flow control
   output logic      rts_n
);
   localparam int BIT_CYCLES = 10417;
   initial begin
      host_txd = 1'b1;
      rts_n    = 1'b1;
   end
   task automatic set_rts(input logic v);
      rts_n <= v;
   endtask : set_rts
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         host_txd <= f[i];
         repeat (BIT_CYCLES) @(posedge clk);
      end
   endtask : send_byte
   // Samples mid-bit so a tick-quantised bit edge cannot flip the result
   task automatic get_byte(output logic [8:0] b);
      wait (host_rxd === 1'b0);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int i = 0; i < 9; i++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         b[i] = host_rxd;
      end
   endtask : get_byte
endmodule : ihu_host_model

/* sim/tb.sv */
`timescale 1ns/1ps
module tb;
   logic        clk, reset_n, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, host_txd, host_rxd, rts_n, cts_n;
   logic        dtr_n, dsr_n, cd_n, ri_n, handler_active;
   logic [8:0]  b;
   int          errors, checks;
   ihu_host_uart #(.PWRUP_CYCLES(20), .OSC_START_CYCLES(10), .LINK_TIMEOUT_CYCLES(2000)) dut (.clk(clk),
      .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .host_txd(host_txd), .host_rxd(host_rxd),
      .rts_n(rts_n), .cts_n(cts_n), .dtr_n(dtr_n), .dsr_n(dsr_n), .cd_n(cd_n), .ri_n(ri_n),
      .handler_active(handler_active));
   ihu_host_model host (.clk(clk), .host_txd(host_txd), .host_rxd(host_rxd), .rts_n(rts_n));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : cmp
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic give_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   task automatic test_startup;
      cmp({host_rxd, cts_n, dsr_n, handler_active}, 4'hE);
      reset_n <= 1'b1;
      apb(1'b0, 12'h004, 0);
      cmp(rd[0], 0);
      apb(1'b1, 12'h010, 32'h0000_0101);
      cmp(err, 1);
      apb(1'b0, 12'h018, 0);
      cmp(err, 1);
      cmp(rd, 0);
      repeat (40) @(posedge clk);
      apb(1'b0, 12'h004, 0);
      cmp({rd[0], cts_n}, 2'b10);
      $display("startup done");
   endtask : test_startup
   task automatic test_modem;
      for (int i = 0; i < 8; i++) begin
         {dtr_n, ri_n, cd_n} <= i[2:0];
         apb(1'b0, 12'h008, 0);
         cmp(rd[2:0], i[2:0]);
      end
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, 12'h000, s);
         @(posedge clk);
         cmp({handler_active, dsr_n}, {s == 1 || s == 2, s != 2});
      end
      $display("modem done");
   endtask : test_modem
   task automatic test_from_host;
      host.send_byte(8'hA5);
      apb(1'b0, 12'h00C, 0);
      cmp(rd[4:0], 1);
      apb(1'b0, 12'h014, 0);
      cmp(rd, 32'h0000_01A5);
      apb(1'b0, 12'h014, 0);
      cmp(rd[8], 0);
      $display("from host done");
   endtask : test_from_host
   task automatic test_to_host;
      host.set_rts(1'b0);
      apb(1'b1, 12'h000, 2);
      apb(1'b1, 12'h010, 32'h0000_013C);
      cmp(err, 0);
      host.get_byte(b);
      cmp(b, 9'h13C);
      host.set_rts(1'b1);
      apb(1'b1, 12'h010, 32'h0000_0155);
      repeat (2500) @(posedge clk);
      apb(1'b0, 12'h004, 0);
      cmp({rd[7], dsr_n, handler_active}, 3'b110);
      apb(1'b1, 12'h004, 32'h0000_0080);
      apb(1'b0, 12'h004, 0);
      cmp(rd[7], 0);
      $display("to host done");
   endtask : test_to_host
   initial begin
      {reset_n, psel, penable, pwrite, paddr, pwdata} = 0;
      {dtr_n, cd_n, ri_n} = 3'b111;
      repeat (8) @(posedge clk);
      test_startup();
      test_modem();
      test_from_host();
      test_to_host();
      give_verdict();
   end
   initial begin
      repeat (400000) @(posedge clk);
      errors++;
      give_verdict();
   end
endmodule : tb
